// ---- iesaw_mst.sv ----
// behavioural two-wire bus master that makes the serial clock from its link clock
`timescale 1ns/10ps
module iesaw_mst (
    input  wire logic lclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // sda_drv low pulls the line, high lets the pull-up win
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask

    task automatic start();
        sda_drv = 1'b1;
        tick(1);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(40);
    endtask

    // one clock pulse; low_all says the line stayed low through the high phase
    task automatic bit_io(input logic b, output logic seen, output logic low_all);
        sda_drv = b;
        tick(2);
        scl = 1'b1;
        low_all = 1'b1;
        repeat (3) begin
            tick(1);
            low_all &= !sda_line;
        end
        seen = sda_line;
        scl = 1'b0;
        tick(1);
    endtask

    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s, ack);
        bit_io(1'b1, s, ack);
    endtask

    task automatic rd(input logic mack, output logic [7:0] d);
        logic s;
        logic l;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, s, l);
            d = {d[6:0], s};
        end
        bit_io(!mack, s, l);
    endtask
endmodule

// ---- iesaw_pkg.sv ----
// constants shared by the serial eeprom slave front end
package iesaw_pkg;
    localparam logic [3:0] CTRL_TYPE    = 4'ha;    // type code 1010
    localparam int         ADDR_W       = 15;
    localparam int         PAGE_BYTES   = 64;
    localparam int         PAGE_AW      = 6;
    localparam logic [2:0] PROT_TOP     = 3'h7;    // addr[14:12] of the locked eighth
    localparam logic [1:0] IDX_CTRL     = 2'h0;
    localparam logic [1:0] IDX_ADDR_HI  = 2'h1;
    localparam logic [1:0] IDX_ADDR_LO  = 2'h2;
    localparam logic [1:0] IDX_DATA     = 2'h3;
    localparam int         TWC_MS       = 5;
    localparam int         CLK_MHZ      = 125;
    localparam int         TWC_CYC      = TWC_MS * 1000 * CLK_MHZ;
    localparam int         WC_W         = 20;
    localparam int         SYNC_W       = 6;
endpackage

// ---- iesaw_slave.sv ----
// two-wire serial eeprom slave: bus conditions, addressing, page write, reads
`timescale 1ns/10ps

// Notes on behaviour
// - respond only when received chip select bits equal the three chip select pins
// - data changes only while clock low; change with clock high is start or stop
// - data falling while clock high is a start; every command begins with one
// - data rising while clock high is a stop; every operation ends with one
// - one bit per clock pulse; master decides byte count
// - addressed receiver acknowledges each byte on a ninth clock pulse
// - acknowledge holds data low across the whole ninth clock high phase
// - master leaves last read byte unacknowledged; device releases data high
// - first byte: type 1010, chip select msb, mid, lsb, then direction bit
// - acknowledge control byte only on type 1010 and select match; pick direction
// - write takes two address bytes high first; only 15 bits kept
// - byte write acknowledges four bytes; stop launches the timed write cycle
// - no acknowledge at all while the write cycle runs
// - a partial page write rewrites the whole page, refreshing other bytes
// - up to 63 further bytes wait in the page buffer until the stop
// - only the low six address bits advance; overflow wraps inside the page
// - writes to the top eighth are blocked; reads there unaffected
// - sequential reads never continue into the next chip
// - the write cycle ends within five milliseconds
// - reads advance the pointer by one, rolling from top address to zero
module iesaw_slave
    import iesaw_pkg::*;
#(
    parameter int WC_CYCLES = TWC_CYC
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic chip_sel_in_msb,
    input  wire logic chip_sel_in_mid,
    input  wire logic chip_sel_in_lsb,
    output logic      write_busy
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACKW, ST_ACK, ST_TX, ST_MACK, ST_TXW, ST_IGNORE
    } iesaw_st_t;

    typedef struct packed {
        iesaw_st_t                       st;
        logic [3:0]                      bitcnt;
        logic [7:0]                      sh;
        logic [1:0]                      byte_idx;
        logic                            rd_op;
        logic [ADDR_W-1:0]               ptr;
        logic [PAGE_BYTES-1:0][7:0]      pbuf;
        logic [PAGE_BYTES-1:0]           pmask;
        logic                            data_acked;
        logic                            busy;
        logic [WC_W-1:0]                 wc_cnt;
        logic                            cm_act;
        logic [PAGE_AW-1:0]              cm_idx;
        logic [ADDR_W-PAGE_AW-1:0]       page;
        logic                            scl_q;
        logic                            sda_q;
        logic [1:0]                      rise_d;
        logic                            sda_o;
        logic                            sda_en;
    } iesaw_state_t;

    localparam logic [WC_W-1:0] WC_LAST = WC_W'(WC_CYCLES - 1);

    generate
        if (WC_CYCLES < PAGE_BYTES + 1 || WC_CYCLES >= (1 << WC_W)) begin : g_chk
            $error("WC_CYCLES must exceed the page commit and fit the counter");
        end
    endgenerate

    iesaw_state_t      s_r;
    iesaw_state_t      s_nxt;
    logic              rx_bit_r;
    logic [SYNC_W-1:0] sync_v;
    logic              scl_s;
    logic              sda_s;
    logic              rx_s;
    logic [2:0]        chip_s;
    logic              bit_evt;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic [7:0]        rx_byte;
    logic [7:0]        mem [0:(1 << ADDR_W)-1];
    logic [7:0]        mem_rd;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0]        mem_wd;
    logic              mem_we;

    // link side: data is sampled on the master's own clock rising edge
    always_ff @(posedge scl) begin
        rx_bit_r <= sda_in;
    end

    iesaw_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in ({chip_sel_in_msb, chip_sel_in_mid, chip_sel_in_lsb, rx_bit_r, sda_in, scl}),
        .sync_out (sync_v)
    );

    assign scl_s     = sync_v[0];
    assign sda_s     = sync_v[1];
    assign rx_s      = sync_v[2];
    assign chip_s    = sync_v[5:3];
    // rise is delayed two cycles so the captured bit has settled through its sync
    assign bit_evt   = s_r.rise_d[1];
    assign scl_fall  = s_r.scl_q & ~scl_s;
    assign start_det = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
    assign stop_det  = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
    assign rx_byte   = {s_r.sh[6:0], rx_s};

    // commit walks the whole page, rewriting untouched bytes with their old value
    assign mem_wa = {s_r.page, s_r.cm_idx};
    assign mem_wd = s_r.pmask[s_r.cm_idx] ? s_r.pbuf[s_r.cm_idx] : mem[mem_wa];
    assign mem_we = s_r.cm_act && (mem_wa[ADDR_W-1:ADDR_W-3] != PROT_TOP);
    assign mem_rd = mem[s_r.ptr];

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_comb begin
        s_nxt        = s_r;
        s_nxt.scl_q  = scl_s;
        s_nxt.sda_q  = sda_s;
        s_nxt.rise_d = {s_r.rise_d[0], scl_s & ~s_r.scl_q};
        s_nxt.sda_o  = 1'b0;
        if (s_r.cm_act) begin
            s_nxt.cm_idx = s_r.cm_idx + 1'b1;
            if (s_r.cm_idx == PAGE_AW'(PAGE_BYTES - 1)) begin
                s_nxt.cm_act = 1'b0;
                s_nxt.pmask  = '0;
            end
        end
        if (s_r.busy) begin
            s_nxt.wc_cnt = s_r.wc_cnt + 1'b1;
            if (s_r.wc_cnt == WC_LAST) begin
                s_nxt.busy = 1'b0;
            end
        end
        if (stop_det) begin
            s_nxt.st     = ST_IDLE;
            s_nxt.sda_en = 1'b0;
            if (!s_r.rd_op && s_r.data_acked && !s_r.busy) begin
                s_nxt.busy   = 1'b1;
                s_nxt.wc_cnt = '0;
                s_nxt.cm_act = 1'b1;
                s_nxt.cm_idx = '0;
                s_nxt.page   = s_r.ptr[ADDR_W-1:PAGE_AW];
            end else if (!s_r.cm_act) begin
                s_nxt.pmask = '0;
            end
            s_nxt.data_acked = 1'b0;
        end else if (start_det) begin
            s_nxt.st         = ST_RX;
            s_nxt.bitcnt     = '0;
            s_nxt.byte_idx   = IDX_CTRL;
            s_nxt.sda_en     = 1'b0;
            s_nxt.data_acked = 1'b0;
            s_nxt.rd_op      = 1'b0;
            if (!s_r.cm_act) begin
                s_nxt.pmask = '0;
            end
        end else begin
            case (s_r.st)
                ST_RX: begin
                    if (bit_evt) begin
                        s_nxt.sh     = rx_byte;
                        s_nxt.bitcnt = s_r.bitcnt + 1'b1;
                        if (s_r.bitcnt == 4'h7) begin
                            s_nxt.st = ST_ACKW;
                            case (s_r.byte_idx)
                                IDX_CTRL: begin
                                    s_nxt.rd_op = rx_byte[0];
                                    if (rx_byte[7:4] != CTRL_TYPE || rx_byte[3:1] != chip_s
                                        || s_r.busy) begin
                                        s_nxt.st = ST_IGNORE;
                                    end
                                end
                                IDX_ADDR_HI: begin
                                    s_nxt.ptr[ADDR_W-1:8] = rx_byte[ADDR_W-9:0];
                                end
                                IDX_ADDR_LO: begin
                                    s_nxt.ptr[7:0] = rx_byte;
                                end
                                default: begin
                                    s_nxt.pbuf[s_r.ptr[PAGE_AW-1:0]]  = rx_byte;
                                    s_nxt.pmask[s_r.ptr[PAGE_AW-1:0]] = 1'b1;
                                    s_nxt.ptr[PAGE_AW-1:0] = s_r.ptr[PAGE_AW-1:0] + 1'b1;
                                end
                            endcase
                        end
                    end
                end
                ST_ACKW: begin
                    if (scl_fall) begin
                        s_nxt.sda_en = 1'b1;
                        s_nxt.st     = ST_ACK;
                    end
                end
                ST_ACK: begin
                    // held across the ninth high phase, released on its falling edge
                    if (scl_fall) begin
                        s_nxt.sda_en = 1'b0;
                        s_nxt.bitcnt = '0;
                        if (s_r.byte_idx == IDX_DATA) begin
                            s_nxt.data_acked = 1'b1;
                        end
                        if (s_r.byte_idx == IDX_CTRL && s_r.rd_op) begin
                            s_nxt.sh     = {mem_rd[6:0], 1'b0};
                            s_nxt.sda_en = ~mem_rd[7];
                            s_nxt.bitcnt = 4'h1;
                            s_nxt.ptr    = s_r.ptr + 1'b1;
                            s_nxt.st     = ST_TX;
                        end else begin
                            if (s_r.byte_idx != IDX_DATA) begin
                                s_nxt.byte_idx = s_r.byte_idx + 1'b1;
                            end
                            s_nxt.st = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (s_r.bitcnt == 4'h8) begin
                            s_nxt.sda_en = 1'b0;
                            s_nxt.st     = ST_MACK;
                        end else begin
                            s_nxt.sda_en = ~s_r.sh[7];
                            s_nxt.sh     = {s_r.sh[6:0], 1'b0};
                            s_nxt.bitcnt = s_r.bitcnt + 1'b1;
                        end
                    end
                end
                ST_MACK: begin
                    if (bit_evt) begin
                        if (!rx_s) begin
                            s_nxt.sh  = mem_rd;
                            s_nxt.ptr = s_r.ptr + 1'b1;
                            s_nxt.st  = ST_TXW;
                        end else begin
                            s_nxt.st = ST_IGNORE;
                        end
                    end
                end
                ST_TXW: begin
                    if (scl_fall) begin
                        s_nxt.sda_en = ~s_r.sh[7];
                        s_nxt.sh     = {s_r.sh[6:0], 1'b0};
                        s_nxt.bitcnt = 4'h1;
                        s_nxt.st     = ST_TX;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    s_nxt.sda_en = 1'b0;
                end
                default: begin
                    s_nxt.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out    = s_r.sda_o;
    assign sda_oe     = s_r.sda_en;
    assign write_busy = s_r.busy;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    ctrl_match_a: assert property (
        (s_r.st == ST_ACKW && s_r.byte_idx == IDX_CTRL)
        |-> (s_r.sh[7:4] == CTRL_TYPE && s_r.sh[3:1] == chip_s && !s_r.busy))
        else $error("control byte accepted without type and select match");
    busy_no_ack_a: assert property (
        s_r.busy |-> !s_r.sda_en)
        else $error("acknowledge driven during write cycle");
    start_abort_a: assert property (
        start_det && !stop_det |=> (s_r.st == ST_RX && s_r.bitcnt == 4'h0 && !s_r.sda_en))
        else $error("start did not restart byte reception");
    stop_idle_a: assert property (
        stop_det |=> (s_r.st == ST_IDLE && !s_r.sda_en))
        else $error("stop did not return to idle");
    launch_a: assert property (
        (stop_det && s_r.data_acked && !s_r.rd_op && !s_r.busy)
        |=> (s_r.busy && s_r.cm_act && s_r.wc_cnt == '0))
        else $error("stop after acknowledged data did not launch write");
    no_launch_a: assert property (
        (stop_det && !s_r.data_acked && !s_r.busy) |=> !s_r.busy)
        else $error("write cycle launched without acknowledged data");
    page_wrap_a: assert property (
        (s_r.st == ST_RX && bit_evt && s_r.bitcnt == 4'h7 && s_r.byte_idx == IDX_DATA)
        |=> (s_r.ptr[ADDR_W-1:PAGE_AW] == $past(s_r.ptr[ADDR_W-1:PAGE_AW])))
        else $error("data byte moved pointer outside its page");
    protect_a: assert property (
        mem_we |-> (mem_wa[ADDR_W-1:ADDR_W-3] != PROT_TOP))
        else $error("write reached protected upper eighth");
    wc_bound_a: assert property (
        s_r.busy |-> (s_r.wc_cnt <= WC_LAST))
        else $error("write cycle ran past its limit");
    ack_hold_a: assert property (
        (s_r.st == ST_ACK && scl_s) |-> s_r.sda_en)
        else $error("acknowledge released during clock high");
    mack_release_a: assert property (
        (s_r.st == ST_MACK) |-> !s_r.sda_en)
        else $error("data line held while master acknowledges");
endmodule

// ---- iesaw_sync.sv ----
// two-flop synchroniser for levels entering the ref_clk domain
`timescale 1ns/10ps
module iesaw_sync
    import iesaw_pkg::*;
#(
    parameter int WIDTH = SYNC_W
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("iesaw_sync width must be at least one");
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the serial eeprom slave front end
`timescale 1ns/10ps
module testbench
    import iesaw_pkg::*;
;
    localparam int WCC = 2000;
    logic       ref_clk = 1'b0;
    logic       lclk    = 1'b0;
    logic       srst    = 1'b1;
    logic [2:0] sel_pins = 3'h5;
    logic       scl, sda_m, sda_oe, sda_out, write_busy, sda_line;
    int         n_fail = 0;
    int         comparisons = 0;

    always #4 ref_clk = ~ref_clk;
    initial begin
        #2.5;
        forever #16 lclk = ~lclk;
    end
    assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

    iesaw_slave #(.WC_CYCLES(WCC)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_in_msb(sel_pins[2]),
        .chip_sel_in_mid(sel_pins[1]), .chip_sel_in_lsb(sel_pins[0]),
        .write_busy(write_busy)
    );
    iesaw_mst mst_u (.lclk(lclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_m));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic exp, input string nm);
        logic a;
        mst_u.wr(b, a);
        chk(nm, 16'(a), 16'(exp));
    endtask

    task automatic set_addr(input logic [15:0] a);
        mst_u.start();
        send({CTRL_TYPE, 3'h5, 1'b0}, 1'b1, "ctrl_w");
        send(a[15:8], 1'b1, "addr_hi");
        send(a[7:0], 1'b1, "addr_lo");
    endtask

    task automatic wr_seq(input logic [15:0] a, input logic [7:0] d[$]);
        set_addr(a);
        foreach (d[i]) send(d[i], 1'b1, "data");
        mst_u.stop();
    endtask

    task automatic rd_seq(input logic [15:0] a, input logic [7:0] e[$], input logic cmp,
                          output logic [7:0] d);
        set_addr(a);
        mst_u.start();
        send({CTRL_TYPE, 3'h5, 1'b1}, 1'b1, "ctrl_r");
        foreach (e[i]) begin
            mst_u.rd(i < e.size() - 1, d);
            if (cmp) chk("rd_data", 16'(d), 16'(e[i]));
        end
        mst_u.stop();
    endtask

    // waits out a write cycle, optionally by acknowledge polling
    task automatic commit_wait(input logic poll);
        logic a;
        int   n;
        chk("busy_rise", 16'(write_busy), 16'h0001);
        n = 0;
        a = 1'b0;
        while (poll && !a && n < 40) begin
            mst_u.start();
            mst_u.wr({CTRL_TYPE, 3'h5, 1'b0}, a);
            mst_u.stop();
            n++;
        end
        if (poll) chk("polls_refused", 16'(n > 1), 16'h0001);
        n = 0;
        while (write_busy !== 1'b0 && n < WCC + 8) begin
            @(negedge ref_clk);
            n++;
        end
        // without polling the wait starts about 160 cycles after the stop
        chk("busy_len", 16'(n <= WCC && (poll || n >= WCC - 400)), 16'h0001);
        if (write_busy !== 1'b0) complete_run();
    endtask

    task automatic s_select();
        for (int p = 0; p < 8; p++) begin
            @(negedge ref_clk);
            sel_pins = 3'(p);
            mst_u.start();
            send({CTRL_TYPE, 3'h5, 1'b0}, p == 5, "sel_match");
            mst_u.stop();
        end
        // back to the matching strap so only the type code can refuse
        @(negedge ref_clk);
        sel_pins = 3'h5;
        mst_u.start();
        send({4'h6, 3'h5, 1'b0}, 1'b0, "bad_type");
        mst_u.stop();
    endtask

    task automatic s_abandon();
        logic s;
        logic l;
        mst_u.start();
        mst_u.bit_io(1'b1, s, l);
        mst_u.bit_io(1'b0, s, l);
        mst_u.bit_io(1'b1, s, l);
        set_addr(16'h0010);
        mst_u.stop();
        chk("no_commit", 16'(write_busy), 16'h0000);
    endtask

    task automatic s_page();
        logic [7:0] d;
        wr_seq(16'h0120, {8'h11, 8'h22, 8'h33});
        commit_wait(1'b1);
        // bit 15 of the address is ignored, so this lands in the same page
        wr_seq(16'h8123, {8'h3C});
        commit_wait(1'b0);
        rd_seq(16'h0120, {8'h11, 8'h22, 8'h33, 8'h3C}, 1'b1, d);
    endtask

    task automatic s_wrap();
        logic [7:0] d;
        wr_seq(16'h007E, {8'hA1, 8'hB2, 8'hC3});
        commit_wait(1'b0);
        rd_seq(16'h007E, {8'hA1, 8'hB2}, 1'b1, d);
        rd_seq(16'h0040, {8'hC3}, 1'b1, d);
    endtask

    task automatic s_protect();
        logic [7:0] d;
        wr_seq(16'h6FFF, {8'h5A});
        commit_wait(1'b0);
        wr_seq(16'h7000, {8'hA5});
        commit_wait(1'b0);
        rd_seq(16'h6FFF, {8'h5A}, 1'b1, d);
        rd_seq(16'h7000, {8'h00}, 1'b0, d);
        chk("prot_kept", 16'(d === 8'hA5), 16'h0000);
    endtask

    initial begin
        repeat (5) @(negedge ref_clk);
        srst = 1'b0;
        repeat (8) @(negedge ref_clk);
        s_select();
        s_abandon();
        s_page();
        s_wrap();
        s_protect();
        complete_run();
    end
endmodule
